/* hw/drpc_bank.sv */
// What this block does
// - writing 1 to the audio FIFO error-clear bit clears the latched audio FIFO error; a new error arriving in the same cycle wins and stays latched.
// - the audio strobe bit at 1 strobes audio data on the rising edge, at 0 on the falling edge.
// - pixel-clock test bit 7 set selects the external test clock pin as pixel clock source.
// - with lock mode 0 the lock indication is high only while linked and video is not off.
// - with lock mode 1 the lock indication is high whenever linked to a serializer.
// - raw back-channel bit 5 set forwards general-purpose pin 0 unfiltered to the serializer.
// - the two-bit input mode selects auto, forced dual, forced primary or forced secondary.
// - port-1 select set makes writes update port-1 and shared registers.
// - port-1 select set makes reads return port-1 copies; software clears it to read port 0.
// - port-0 select set makes writes update port-0 and shared registers, reads return port 0 while port-1 select is clear.
// - with both selects set, port-specific reads return the port-1 copy.
// - the dual-receiver control register resets to 0x01.
`timescale 1ns/1ps
`default_nettype none
`include "drpc_consts.svh"

module drpc_bank
	import drpc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire drpc_req_t req_in,
	output logic [7:0] rdata_out,
	output logic rvalid_out,
	input wire logic fifo_err_set_in,
	output logic fifo_err_out,
	output logic strobe_rising_out,
	input wire logic test_clock_input_pin_in,
	input wire logic pll_pclk_in,
	output logic pclk_sel_out,
	output logic pclk_out,
	input wire logic linked_in,
	input wire logic forward_video_off_flag_in,
	output logic rx_lock_out,
	input wire logic general_purpose_pin_zero_in,
	input wire logic filtered_bc_in,
	output logic bc_data_out,
	output drpc_mode_t dual_input_mode_field_out,
	output logic [7:0] aeq_port0_out,
	output logic [7:0] aeq_port1_out
);
	// ==========================================================
	// pin synchronisers
	logic [1:0] gpio_sync_r;
	logic [1:0] link_sync_r;
	logic [1:0] voff_sync_r;
	logic [1:0] ferr_sync_r;

	// two flops each; only bit 1 is read by logic
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gpio_sync_r <= 2'h0;
			link_sync_r <= 2'h0;
			voff_sync_r <= 2'h3;
			ferr_sync_r <= 2'h0;
		end else begin
			gpio_sync_r <= {gpio_sync_r[0], general_purpose_pin_zero_in};
			link_sync_r <= {link_sync_r[0], linked_in};
			voff_sync_r <= {voff_sync_r[0], forward_video_off_flag_in};
			ferr_sync_r <= {ferr_sync_r[0], fifo_err_set_in};
		end
	end

	// ==========================================================
	// register storage
	logic [7:0] pclk_test_r;
	logic [7:0] dual_rx_r;
	logic [7:0] audio_ctl_r;
	logic [7:0] aeq_r [2];
	logic fifo_err_r;
	drpc_ctl_t ctl;

	function automatic logic hit(input drpc_req_t r, input logic [7:0] ofs);
		hit = r.addr == ofs;
	endfunction

	wire logic wr_dual = req_in.wr && hit(req_in, `DRPC_DUAL_RX_OFS);
	wire logic wr_pclk = req_in.wr && hit(req_in, `DRPC_PCLK_TEST_OFS);
	wire logic wr_audio = req_in.wr && hit(req_in, `DRPC_AUDIO_CTL_OFS);
	wire logic wr_aeq = req_in.wr && hit(req_in, `DRPC_AEQ_OFS);
	wire logic fifo_clr = wr_audio && req_in.wdata[`DRPC_FIFO_CLR_BIT];

	// shared registers; reserved bits are masked off on write
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			dual_rx_r <= `DRPC_DUAL_RX_RST;
			pclk_test_r <= `DRPC_PCLK_TEST_RST;
			audio_ctl_r <= `DRPC_AUDIO_CTL_RST;
		end else begin
			if (wr_dual)
				dual_rx_r <= req_in.wdata & `DRPC_DUAL_RX_MASK;
			if (wr_pclk)
				pclk_test_r <= req_in.wdata & `DRPC_PCLK_TEST_MASK;
			if (wr_audio)
				audio_ctl_r <= req_in.wdata & `DRPC_AUDIO_CTL_MASK;
		end
	end

	// port-specific copies: each selected port takes the write
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			always_ff @(posedge clk_in) begin
				if (!rst_n_in)
					aeq_r[p] <= `DRPC_AEQ_RST;
				else if (wr_aeq && dual_rx_r[p])
					aeq_r[p] <= req_in.wdata & `DRPC_AEQ_MASK;
			end
		end
	endgenerate

	// latched fifo error; a new error in the clear cycle wins
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			fifo_err_r <= 1'b0;
		else if (ferr_sync_r[1])
			fifo_err_r <= 1'b1;
		else if (fifo_clr)
			fifo_err_r <= 1'b0;
	end

	// ==========================================================
	// read path: port 1 wins when both selects are set
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h0_0;
			rvalid_out <= 1'b0;
		end else begin
			rvalid_out <= req_in.rd;
			if (!req_in.rd)
				rdata_out <= 8'h0_0;
			else if (hit(req_in, `DRPC_DUAL_RX_OFS))
				rdata_out <= dual_rx_r;
			else if (hit(req_in, `DRPC_PCLK_TEST_OFS))
				rdata_out <= pclk_test_r;
			else if (hit(req_in, `DRPC_AUDIO_CTL_OFS))
				rdata_out <= audio_ctl_r;
			else if (hit(req_in, `DRPC_AEQ_OFS))
				rdata_out <= ctl.second_port_access_select ? aeq_r[1] : aeq_r[0];
			else
				rdata_out <= 8'h0_0;
		end
	end

	// ==========================================================
	// field decode and outputs
	always_comb begin
		ctl.ext_pclk = pclk_test_r[`DRPC_EXT_PCLK_BIT];
		ctl.lock_mode = dual_rx_r[`DRPC_LOCK_MODE_BIT];
		ctl.raw_bc = dual_rx_r[`DRPC_RAW_BC_BIT];
		ctl.mode = drpc_mode_t'(dual_rx_r[`DRPC_MODE_MSB:`DRPC_MODE_LSB]);
		ctl.second_port_access_select = dual_rx_r[`DRPC_PORT1_BIT];
		ctl.first_port_access_select = dual_rx_r[`DRPC_PORT0_BIT];
		ctl.strobe_rising = audio_ctl_r[`DRPC_STROBE_BIT];
	end

	// pclk mux is a plain select; a glitch-free switch belongs to the clock tree
	assign pclk_sel_out = ctl.ext_pclk;
	assign pclk_out = ctl.ext_pclk ? test_clock_input_pin_in : pll_pclk_in;

	// registered outputs
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rx_lock_out <= 1'b0;
			bc_data_out <= 1'b0;
			dual_input_mode_field_out <= DRPC_MODE_AUTO;
			strobe_rising_out <= 1'b0;
			fifo_err_out <= 1'b0;
		end else begin
			rx_lock_out <= link_sync_r[1] && (ctl.lock_mode || !voff_sync_r[1]);
			bc_data_out <= ctl.raw_bc ? gpio_sync_r[1] : filtered_bc_in;
			dual_input_mode_field_out <= ctl.mode;
			strobe_rising_out <= ctl.strobe_rising;
			fifo_err_out <= fifo_err_r;
		end
	end

	assign aeq_port0_out = aeq_r[0];
	assign aeq_port1_out = aeq_r[1];

	// ==========================================================
	// checks: all sit in the clk_in domain; all but the two reset checks drop out while reset is low
	// select states and access kinds are named once, so each property reads as select plus access
	sequence both_sel_s;
		ctl.second_port_access_select && ctl.first_port_access_select;
	endsequence

	sequence port1_only_s;
		ctl.second_port_access_select && !ctl.first_port_access_select;
	endsequence

	sequence port0_only_s;
		!ctl.second_port_access_select && ctl.first_port_access_select;
	endsequence

	sequence no_sel_s;
		!ctl.second_port_access_select && !ctl.first_port_access_select;
	endsequence

	sequence aeq_read_s;
		req_in.rd && hit(req_in, `DRPC_AEQ_OFS);
	endsequence

	sequence aeq_write_s;
		wr_aeq;
	endsequence

	// a read that hits none of the four offsets
	sequence unmapped_read_s;
		req_in.rd && !hit(req_in, `DRPC_DUAL_RX_OFS) && !hit(req_in, `DRPC_PCLK_TEST_OFS)
			&& !hit(req_in, `DRPC_AUDIO_CTL_OFS) && !hit(req_in, `DRPC_AEQ_OFS);
	endsequence

	// reset: the first edge that sees reset released still shows the reset values
	reset_value_a: assert property (@(posedge clk_in)
		$rose(rst_n_in) |-> dual_rx_r == `DRPC_DUAL_RX_RST)
		else $error("dual rx control not at its reset value after reset");

	reset_outputs_a: assert property (@(posedge clk_in)
		$rose(rst_n_in) |-> !rx_lock_out && !bc_data_out && !fifo_err_out && !strobe_rising_out
			&& dual_input_mode_field_out == DRPC_MODE_AUTO)
		else $error("outputs not cleared by reset");

	// lock indication: one register after the synchronised link and video-off levels
	lock_video_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!ctl.lock_mode && voff_sync_r[1]) |=> !rx_lock_out)
		else $error("lock high with video off in mode 0");

	lock_active_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!ctl.lock_mode && link_sync_r[1] && !voff_sync_r[1]) |=> rx_lock_out)
		else $error("lock low with active video in mode 0");

	lock_link_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ctl.lock_mode && link_sync_r[1]) |=> rx_lock_out)
		else $error("lock low while linked in mode 1");

	lock_unlinked_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!link_sync_r[1] |=> !rx_lock_out)
		else $error("lock high while not linked");

	// back channel: raw mode bypasses the filter but not the synchroniser
	raw_bc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ctl.raw_bc |=> bc_data_out == $past(gpio_sync_r[1]))
		else $error("raw back channel not forwarding pin");

	filt_bc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!ctl.raw_bc |=> bc_data_out == $past(filtered_bc_in))
		else $error("filtered back channel not forwarded");

	// fifo error: a clear only wins when no new error arrives in the same cycle
	fifo_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(fifo_clr && !ferr_sync_r[1]) |=> !fifo_err_r ##1 !fifo_err_out)
		else $error("fifo error not cleared");

	fifo_set_wins_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ferr_sync_r[1] |=> fifo_err_r ##1 fifo_err_out)
		else $error("fifo error lost against a clear");

	// port copies: the selects steer writes to copies and reads from one copy
	port1_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		both_sel_s ##0 aeq_read_s |=> rdata_out == $past(aeq_r[1]))
		else $error("both selects did not read port 1");

	port1_only_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		port1_only_s ##0 aeq_read_s |=> rdata_out == $past(aeq_r[1]))
		else $error("port 1 select did not read port 1");

	port0_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		port0_only_s ##0 aeq_read_s |=> rdata_out == $past(aeq_r[0]))
		else $error("port 0 select did not read port 0");

	dual_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		both_sel_s ##0 aeq_write_s |=> aeq_r[0] == ($past(req_in.wdata) & `DRPC_AEQ_MASK)
			&& aeq_r[1] == ($past(req_in.wdata) & `DRPC_AEQ_MASK))
		else $error("both selects did not write both ports");

	port1_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		port1_only_s ##0 aeq_write_s |=> aeq_r[1] == ($past(req_in.wdata) & `DRPC_AEQ_MASK)
			&& $stable(aeq_r[0]))
		else $error("port 1 select did not write port 1 alone");

	port0_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		port0_only_s ##0 aeq_write_s |=> aeq_r[0] == ($past(req_in.wdata) & `DRPC_AEQ_MASK)
			&& $stable(aeq_r[1]))
		else $error("port 0 select did not write port 0 alone");

	no_sel_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		no_sel_s ##0 aeq_write_s |=> $stable(aeq_r[0]) && $stable(aeq_r[1]))
		else $error("write with no select changed a port copy");

	shared_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_pclk |=> pclk_test_r == ($past(req_in.wdata) & `DRPC_PCLK_TEST_MASK))
		else $error("shared register not written");

	// reserved bits and holes in the map always read zero
	reserved_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_dual |=> (dual_rx_r & ~`DRPC_DUAL_RX_MASK) == 8'h0_0)
		else $error("reserved bits not zero");

	reserved_audio_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_audio |=> (audio_ctl_r & ~`DRPC_AUDIO_CTL_MASK) == 8'h0_0)
		else $error("audio reserved or clear bit stored");

	unmapped_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		unmapped_read_s |=> rdata_out == 8'h0_0)
		else $error("unmapped read not zero");

	// mode and strobe reach their outputs one register after the write lands; the pclk select follows it with no register
	pclk_sel_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_pclk && req_in.wdata[`DRPC_EXT_PCLK_BIT]) |=> pclk_sel_out)
		else $error("external pixel clock not selected");

	pclk_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_pclk && !req_in.wdata[`DRPC_EXT_PCLK_BIT]) |=> !pclk_sel_out)
		else $error("external pixel clock not released");

	mode_out_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_dual |=> ##1 dual_input_mode_field_out
			== drpc_mode_t'($past(req_in.wdata[`DRPC_MODE_MSB:`DRPC_MODE_LSB], 2)))
		else $error("input mode not applied");

	strobe_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_audio |=> ##1 strobe_rising_out == $past(req_in.wdata[`DRPC_STROBE_BIT], 2))
		else $error("strobe edge not applied");
endmodule
`default_nettype wire

/* include/drpc_consts.svh */
`ifndef DRPC_CONSTS_SVH
`define DRPC_CONSTS_SVH

// ==========================================================
// register offsets
`define DRPC_AUDIO_CTL_OFS 8'h2_d
`define DRPC_PCLK_TEST_OFS 8'h2_e
`define DRPC_DUAL_RX_OFS 8'h3_4
`define DRPC_AEQ_OFS 8'h3_5

// ==========================================================
// reset values
`define DRPC_PCLK_TEST_RST 8'h0_0
`define DRPC_DUAL_RX_RST 8'h0_1
`define DRPC_AUDIO_CTL_RST 8'h0_0
`define DRPC_AEQ_RST 8'h0_0

// ==========================================================
// writable masks (reserved bits read zero)
`define DRPC_PCLK_TEST_MASK 8'h8_0
`define DRPC_DUAL_RX_MASK 8'h7_b
`define DRPC_AUDIO_CTL_MASK 8'h0_1
`define DRPC_AEQ_MASK 8'h7_0

// ==========================================================
// field positions
`define DRPC_FIFO_CLR_BIT 1
`define DRPC_EXT_PCLK_BIT 7
`define DRPC_LOCK_MODE_BIT 6
`define DRPC_RAW_BC_BIT 5
`define DRPC_PORT1_BIT 1
`define DRPC_PORT0_BIT 0
`define DRPC_STROBE_BIT 0
`define DRPC_MODE_MSB 4
`define DRPC_MODE_LSB 3

`endif

/* include/drpc_pkg.sv */
`default_nettype none
package drpc_pkg;
	// dual-input operating mode
	typedef enum logic [1:0] {
		DRPC_MODE_AUTO = 2'h0,
		DRPC_MODE_DUAL = 2'h1,
		DRPC_MODE_PRI = 2'h2,
		DRPC_MODE_SEC = 2'h3
	} drpc_mode_t;

	// one control-bus register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} drpc_req_t;

	// decoded control fields
	typedef struct packed {
		logic ext_pclk;
		logic lock_mode;
		logic raw_bc;
		drpc_mode_t mode;
		logic second_port_access_select;
		logic first_port_access_select;
		logic strobe_rising;
	} drpc_ctl_t;

	typedef enum {
		DRPC_IDLE,
		DRPC_CLEAR
	} drpc_clr_state_t;
endpackage
`default_nettype wire

/* tb/drpc_ser_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side serializer: link state and filtered back channel, driven on the falling edge
module drpc_ser_model (
	input wire logic clk_in,
	input wire logic [2:0] cmd_in,
	output logic linked_out,
	output logic video_off_out,
	output logic filt_bc_out
);
	// start unlinked so the lock path begins from a known level
	initial {linked_out, video_off_out, filt_bc_out} = 3'h0;
	// cmd bits: linked, video off, filtered back-channel bit
	always @(negedge clk_in) begin
		{linked_out, video_off_out, filt_bc_out} <= cmd_in;
	end
endmodule
`default_nettype wire

/* tb/tb_drpc_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_drpc_bank;
	import drpc_pkg::*;
	logic clk_in = 0, rst_n_in = 0, fset = 0, tclk = 0, pclk = 0, gpio = 0;
	logic [2:0] cmd = 3'h0;
	drpc_req_t req = '0;
	logic [7:0] rdata, a0, a1;
	logic rv, ferr, srise, psel, pco, lnk, voff, fbc, lock, bc;
	drpc_mode_t mode;
	int error_cnt = 0, num_checks = 0;
	// ==========================================================
	// clocks: pixel clocks at periods that never toggle on a sample point
	always #25 clk_in = ~clk_in;
	always #10 tclk = ~tclk;
	always #15 pclk = ~pclk;
	drpc_bank dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .rdata_out(rdata),
		.rvalid_out(rv), .fifo_err_set_in(fset), .fifo_err_out(ferr), .strobe_rising_out(srise),
		.test_clock_input_pin_in(tclk), .pll_pclk_in(pclk), .pclk_sel_out(psel), .pclk_out(pco),
		.linked_in(lnk), .forward_video_off_flag_in(voff), .rx_lock_out(lock),
		.general_purpose_pin_zero_in(gpio), .filtered_bc_in(fbc), .bc_data_out(bc),
		.dual_input_mode_field_out(mode), .aeq_port0_out(a0), .aeq_port1_out(a1));
	drpc_ser_model ser_u (.clk_in(clk_in), .cmd_in(cmd), .linked_out(lnk), .video_off_out(voff),
		.filt_bc_out(fbc));
	// ==========================================================
	// helpers
	function automatic logic [7:0] z(input logic b);
		return {7'h0_0, b};
	endfunction
	task chk(input logic [7:0] g, e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// one-cycle write pulse; it lands at the rising edge in between
	task wr(input logic [7:0] a, d);
		@(negedge clk_in);
		req <= '{1'b1, 1'b0, a, d};
		@(negedge clk_in);
		req <= '0;
	endtask
	// read data stands only in the cycle after the taking edge
	task rd(input logic [7:0] a, e);
		@(negedge clk_in);
		req <= '{1'b0, 1'b1, a, 8'h0_0};
		@(negedge clk_in);
		req <= '0;
		chk(z(rv), 8'h0_1);
		chk(rdata, e);
	endtask
	task t_regs;
		rd(8'h3_4, 8'h0_1);
		rd(8'h2_e, 8'h0_0);
		wr(8'h3_4, 8'hf_f);
		rd(8'h3_4, 8'h7_b);
		wr(8'h2_e, 8'hf_f);
		rd(8'h2_e, 8'h8_0);
		rd(8'h4_0, 8'h0_0);
		wr(8'h3_4, 8'h0_1);
		$display("test regs done");
	endtask
	task t_pclk;
		for (int s = 0; s < 2; s++) begin
			wr(8'h2_e, s ? 8'h8_0 : 8'h0_0);
			repeat (4) begin
				cyc(1);
				#3;
				chk(z(pco), z(s ? tclk : pclk));
				chk(z(psel), z(s[0]));
			end
		end
		$display("test pclk done");
	endtask
	task t_ports;
		wr(8'h3_5, 8'h1_0);
		wr(8'h3_4, 8'h0_2);
		wr(8'h2_e, 8'h8_0);
		rd(8'h2_e, 8'h8_0);
		wr(8'h2_e, 8'h0_0);
		wr(8'h3_5, 8'h2_0);
		chk(a0, 8'h1_0);
		chk(a1, 8'h2_0);
		rd(8'h3_5, 8'h2_0);
		wr(8'h3_4, 8'h0_1);
		rd(8'h3_5, 8'h1_0);
		wr(8'h3_4, 8'h0_3);
		rd(8'h3_5, 8'h2_0);
		wr(8'h3_5, 8'h7_0);
		chk(a0, 8'h7_0);
		chk(a1, 8'h7_0);
		wr(8'h3_4, 8'h0_0);
		wr(8'h3_5, 8'h1_0);
		chk(a0, 8'h7_0);
		chk(a1, 8'h7_0);
		wr(8'h3_4, 8'h0_1);
		$display("test ports done");
	endtask
	// lock path has two sync flops and a register, so five cycles cover it
	task t_lock;
		for (int m = 0; m < 2; m++) begin
			for (int v = 0; v < 2; v++) begin
				wr(8'h3_4, m ? 8'h4_1 : 8'h0_1);
				cmd <= {1'b1, v[0], 1'b0};
				cyc(5);
				chk(z(lock), z(v == 0 || m == 1));
			end
		end
		cmd <= 3'h0;
		cyc(5);
		chk(z(lock), 8'h0_0);
		$display("test lock done");
	endtask
	task t_bc;
		for (int r = 0; r < 2; r++) begin
			for (int b = 0; b < 2; b++) begin
				wr(8'h3_4, r ? 8'h2_1 : 8'h0_1);
				gpio <= b[0];
				cmd <= {2'h2, ~b[0]};
				cyc(5);
				chk(z(bc), z(r ? b[0] : ~b[0]));
			end
		end
		$display("test bc done");
	endtask
	task t_mode;
		for (int m = 0; m < 4; m++) begin
			wr(8'h3_4, {3'h0, m[1:0], 3'h1});
			cyc(1);
			chk({6'h0_0, mode}, {6'h0_0, m[1:0]});
		end
		$display("test mode done");
	endtask
	task t_audio;
		fset <= 1'b1;
		cyc(1);
		fset <= 1'b0;
		cyc(5);
		chk(z(ferr), 8'h0_1);
		wr(8'h2_d, 8'h0_2);
		cyc(2);
		chk(z(ferr), 8'h0_0);
		wr(8'h2_d, 8'h0_1);
		cyc(1);
		chk(z(srise), 8'h0_1);
		rd(8'h2_d, 8'h0_1);
		wr(8'h2_d, 8'h0_0);
		cyc(1);
		chk(z(srise), 8'h0_0);
		$display("test audio done");
	endtask
	// a mid-run reset must clear the lock, mode and back-channel outputs and bring the control register back
	task t_reset;
		wr(8'h3_4, 8'h7_b);
		cyc(2);
		rst_n_in <= 1'b0;
		cyc(3);
		chk(z(lock), 8'h0_0);
		chk({6'h0_0, mode}, 8'h0_0);
		chk(z(bc), 8'h0_0);
		rst_n_in <= 1'b1;
		rd(8'h3_4, 8'h0_1);
		rd(8'h3_5, 8'h0_0);
		$display("test reset done");
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// main sequence after ten reset cycles
	initial begin
		cyc(10);
		rst_n_in <= 1'b1;
		t_regs;
		t_pclk;
		t_ports;
		t_lock;
		t_bc;
		t_mode;
		t_audio;
		t_reset;
		summarize;
	end
	// watchdog well beyond the under two hundred cycles the tests need
	initial begin
		#1_000_000;
		error_cnt++;
		summarize;
	end
endmodule
`default_nettype wire
